// File: design/pll_lock_params.svh
`ifndef PLL_LOCK_PARAMS_SVH
`define PLL_LOCK_PARAMS_SVH
`define IDX_STATUS_AB 8'h17
`define IDX_LOCK_CAL  8'h18
`define IDX_LOCKPIN   8'h1a
`define IDX_MONPIN    8'h1b
`define IDX_REFIN     8'h1c
`define IDX_HOLDOVER  8'h1d
`define IDX_STATE     8'h20
`define REG_RESET     8'h00
`define LD_CNT_LSB    5
`define LD_WIN_BIT    4
`define LD_DIS_BIT    3
`define HO_EN0_BIT    0
`define HO_EXT_BIT    1
`define HO_EN2_BIT    2
`define HO_CMP_BIT    3
`define NEED_00       8'h05
`define NEED_01       8'h10
`define NEED_10       8'h40
`define NEED_11       8'hff
`define LOCK_THR_HI   8'h03
`define LOCK_THR_LO   8'h01
`define UNLOCK_THR_HI 8'h06
`define UNLOCK_THR_LO 8'h03
`define LSEL_DLD      6'h01
`define LSEL_CSRC     6'h04
`define MSEL_DLD      6'h01
`define MSEL_CMP_HI   6'h02
`define MSEL_CMP_LO   6'h03
`define QUAL_TERM     8'h40
`endif

// File: design/pll_lock_pkg.sv
package pll_lock_pkg;
  typedef enum logic [1:0] {
    HO_IDLE  = 2'b00,
    HO_HIZ   = 2'b01,
    HO_RELCK = 2'b11
  } ho_state_t;
endpackage

// File: design/pll_lock_detect_holdover.sv
`timescale 1ns/1ps
`default_nettype none
`include "pll_lock_params.svh"
module pll_lock_detect_holdover
  import pll_lock_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        ref_pfd_i,
  input  wire logic        fb_pfd_i,
  input  wire logic        syncn_i,
  output logic             lock_pin_o,
  output logic             status_pin_o,
  output logic             reference_monitor_pin_pin_o,
  output logic             cp_hiz_o,
  output logic             b_cnt_reset_o
);
  // register file over AHB-Lite
  logic [7:0]  r17_r, r18_r, r1a_r, r1b_r, r1c_r, r1d_r;
  logic [7:0]  r17_nxt, r18_nxt, r1a_nxt, r1b_nxt, r1c_nxt, r1d_nxt;
  logic        wpend_r, wpend_nxt;
  logic [7:0]  widx_r, widx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0]  aidx;
  logic        aphase;
  logic [7:0]  state_rd;

  assign aidx   = haddr_i[9:2];
  assign aphase = hsel_i && htrans_i[1] && hready_i;

  always_comb begin
    r17_nxt   = r17_r;
    r18_nxt   = r18_r;
    r1a_nxt   = r1a_r;
    r1b_nxt   = r1b_r;
    r1c_nxt   = r1c_r;
    r1d_nxt   = r1d_r;
    // only whole-word writes are taken
    wpend_nxt = aphase && hwrite_i && (hsize_i == 3'h2);
    widx_nxt  = aidx;
    rdata_nxt = 32'h0000_0000;
    if (wpend_r) begin
      unique case (widx_r)
        `IDX_STATUS_AB: r17_nxt = hwdata_i[7:0];
        `IDX_LOCK_CAL:  r18_nxt = hwdata_i[7:0];
        `IDX_LOCKPIN:   r1a_nxt = hwdata_i[7:0];
        `IDX_MONPIN:    r1b_nxt = hwdata_i[7:0];
        `IDX_REFIN:     r1c_nxt = hwdata_i[7:0];
        `IDX_HOLDOVER:  r1d_nxt = hwdata_i[7:0];
        default: ;
      endcase
    end
    if (aphase && !hwrite_i && (haddr_i[31:10] == 22'h00_0000)) begin
      unique case (aidx)
        `IDX_STATUS_AB: rdata_nxt = {24'h00_0000, r17_r};
        `IDX_LOCK_CAL:  rdata_nxt = {24'h00_0000, r18_r};
        `IDX_LOCKPIN:   rdata_nxt = {24'h00_0000, r1a_r};
        `IDX_MONPIN:    rdata_nxt = {24'h00_0000, r1b_r};
        `IDX_REFIN:     rdata_nxt = {24'h00_0000, r1c_r};
        `IDX_HOLDOVER:  rdata_nxt = {24'h00_0000, r1d_r};
        `IDX_STATE:     rdata_nxt = {24'h00_0000, state_rd};
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r17_r   <= `REG_RESET;
      r18_r   <= `REG_RESET;
      r1a_r   <= `REG_RESET;
      r1b_r   <= `REG_RESET;
      r1c_r   <= `REG_RESET;
      r1d_r   <= `REG_RESET;
      wpend_r <= 1'b0;
      widx_r  <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      r17_r   <= r17_nxt;
      r18_r   <= r18_nxt;
      r1a_r   <= r1a_nxt;
      r1b_r   <= r1b_nxt;
      r1c_r   <= r1c_nxt;
      r1d_r   <= r1d_nxt;
      wpend_r <= wpend_nxt;
      widx_r  <= widx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // pin synchronisers: three stages, 2nd/3rd must agree
  logic [2:0] s_ref_r, s_fb_r, s_sy_r;
  logic       ref_lv_r, fb_lv_r, sy_lv_r;
  logic       ref_lv_nxt, fb_lv_nxt, sy_lv_nxt;
  logic       ref_rise, fb_rise, sync_fall, sync_high;

  always_comb begin
    ref_lv_nxt = (s_ref_r[1] == s_ref_r[2]) ? s_ref_r[2] : ref_lv_r;
    fb_lv_nxt  = (s_fb_r[1] == s_fb_r[2]) ? s_fb_r[2] : fb_lv_r;
    sy_lv_nxt  = (s_sy_r[1] == s_sy_r[2]) ? s_sy_r[2] : sy_lv_r;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_ref_r  <= 3'h0;
      s_fb_r   <= 3'h0;
      s_sy_r   <= 3'h7;
      ref_lv_r <= 1'b0;
      fb_lv_r  <= 1'b0;
      sy_lv_r  <= 1'b1;
    end else begin
      s_ref_r  <= {s_ref_r[1:0], ref_pfd_i};
      s_fb_r   <= {s_fb_r[1:0], fb_pfd_i};
      s_sy_r   <= {s_sy_r[1:0], syncn_i};
      ref_lv_r <= ref_lv_nxt;
      fb_lv_r  <= fb_lv_nxt;
      sy_lv_r  <= sy_lv_nxt;
    end
  end

  assign ref_rise  = ref_lv_nxt && !ref_lv_r;
  assign fb_rise   = fb_lv_nxt && !fb_lv_r;
  assign sync_fall = !sy_lv_nxt && sy_lv_r;
  assign sync_high = sy_lv_nxt;

  // digital lock indicator
  logic       ld_dis, win_lo;
  logic [7:0] need, lock_thr, unlock_thr, ab_add;
  logic       meas_r, meas_nxt;
  logic [7:0] mcnt_r, mcnt_nxt, diff;
  logic       eval, in_lock, out_lock;
  logic [7:0] lkc_r, lkc_nxt;
  logic       dld_r, dld_nxt;

  assign ld_dis = r18_r[`LD_DIS_BIT];
  assign win_lo = r18_r[`LD_WIN_BIT];
  assign ab_add = {6'h00, r17_r[1:0]};

  always_comb begin
    unique case (r18_r[`LD_CNT_LSB +: 2])
      2'b00:   need = `NEED_00;
      2'b01:   need = `NEED_01;
      2'b10:   need = `NEED_10;
      default: need = `NEED_11;
    endcase
    // bit low picks the high range window
    lock_thr   = (win_lo ? `LOCK_THR_LO : `LOCK_THR_HI) + ab_add;
    unlock_thr = (win_lo ? `UNLOCK_THR_LO : `UNLOCK_THR_HI) + ab_add;
  end

  always_comb begin
    meas_nxt = meas_r;
    mcnt_nxt = mcnt_r;
    eval     = 1'b0;
    diff     = 8'h00;
    if (ref_rise && fb_rise && !meas_r) begin
      eval = 1'b1;
    end else if (!meas_r && (ref_rise || fb_rise)) begin
      meas_nxt = 1'b1;
      mcnt_nxt = 8'h00;
    end else if (meas_r && (ref_rise || fb_rise)) begin
      eval     = 1'b1;
      diff     = mcnt_r + 8'h01;
      meas_nxt = 1'b0;
    end else if (meas_r && (mcnt_r >= unlock_thr)) begin
      // second edge too late: the cycle counts as outside the window
      eval     = 1'b1;
      diff     = mcnt_r + 8'h01;
      meas_nxt = 1'b0;
    end else if (meas_r) begin
      mcnt_nxt = mcnt_r + 8'h01;
    end
    in_lock  = eval && (diff < lock_thr);
    out_lock = eval && (diff > unlock_thr);
    lkc_nxt  = lkc_r;
    dld_nxt  = dld_r;
    if (ld_dis) begin
      lkc_nxt = 8'h00;
      dld_nxt = 1'b0;
    end else if (eval) begin
      if (in_lock) begin
        if (lkc_r < need) lkc_nxt = lkc_r + 8'h01;
        if (lkc_r + 8'h01 >= need) dld_nxt = 1'b1;
      end else begin
        lkc_nxt = 8'h00;
      end
      if (out_lock) dld_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meas_r <= 1'b0;
      mcnt_r <= 8'h00;
      lkc_r  <= 8'h00;
      dld_r  <= 1'b0;
    end else begin
      meas_r <= meas_nxt;
      mcnt_r <= mcnt_nxt;
      lkc_r  <= lkc_nxt;
      dld_r  <= dld_nxt;
    end
  end

  // lock pin, current-source qualification, pin muxes
  logic [7:0] qc_r, qc_nxt;
  logic       csrc, cmp, ld_sense;
  logic       lock_pin_r, lock_pin_nxt;
  logic       status_r, status_nxt, reference_monitor_pin_r, reference_monitor_pin_nxt;

  assign csrc = (r1a_r[5:0] == `LSEL_CSRC);

  always_comb begin
    qc_nxt = qc_r;
    if (!csrc || !dld_r) qc_nxt = 8'h00;
    else if (qc_r < `QUAL_TERM) qc_nxt = qc_r + 8'h01;
  end

  // comparator reads the pin: charged capacitor in current-source mode
  assign cmp      = csrc ? (qc_r == `QUAL_TERM) : lock_pin_r;
  assign ld_sense = r1d_r[`HO_CMP_BIT] ? cmp : 1'b1;

  function automatic logic mon_sel(input logic [5:0] s, input logic d, input logic c);
    mon_sel = (s == `MSEL_DLD) ? d :
              (s == `MSEL_CMP_HI) ? c :
              (s == `MSEL_CMP_LO) ? !c : 1'b0;
  endfunction

  always_comb begin
    // current source while indicator true, ground while false
    lock_pin_nxt = (r1a_r[5:0] == `LSEL_DLD || csrc) ? dld_nxt : 1'b0;
    status_nxt   = mon_sel(r17_r[7:2], dld_r, cmp);
    reference_monitor_pin_nxt   = mon_sel({1'b0, r1b_r[4:0]}, dld_r, cmp);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      qc_r       <= 8'h00;
      lock_pin_r <= 1'b0;
      status_r   <= 1'b0;
      reference_monitor_pin_r   <= 1'b0;
    end else begin
      qc_r       <= qc_nxt;
      lock_pin_r <= lock_pin_nxt;
      status_r   <= status_nxt;
      reference_monitor_pin_r   <= reference_monitor_pin_nxt;
    end
  end

  // holdover controller
  ho_state_t st_r, st_nxt;
  logic      hiz_r, hiz_nxt, brst_r, brst_nxt;
  logic      ho_en, ho_ext;

  assign ho_en  = r1d_r[`HO_EN0_BIT] && r1d_r[`HO_EN2_BIT];
  assign ho_ext = r1d_r[`HO_EXT_BIT];

  always_comb begin
    st_nxt   = st_r;
    brst_nxt = 1'b0;
    if (!ho_en) begin
      st_nxt = HO_IDLE;
    end else begin
      unique case (st_r)
        HO_IDLE: begin
          if (ho_ext && sync_fall) st_nxt = HO_HIZ;
          else if (!ho_ext && !ld_sense) st_nxt = HO_HIZ;
        end
        HO_HIZ: begin
          // leave only on the selected reference's detector edge
          if (ref_rise && (!ho_ext || sync_high)) begin
            brst_nxt = 1'b1;
            st_nxt   = ho_ext ? HO_IDLE : HO_RELCK;
          end
        end
        HO_RELCK: begin
          if (ho_ext) st_nxt = HO_IDLE;
          else if (dld_r && ld_sense) st_nxt = HO_IDLE;
        end
      endcase
    end
    hiz_nxt = (st_nxt == HO_HIZ);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r   <= HO_IDLE;
      hiz_r  <= 1'b0;
      brst_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      hiz_r  <= hiz_nxt;
      brst_r <= brst_nxt;
    end
  end

  // bus ready comes up one edge after power-on, from a flop
  logic resetn_r;
  always_ff @(posedge clk_i) begin
    resetn_r <= 1'b1;
  end

  assign state_rd      = {2'b00, st_r, cmp, ld_sense, hiz_r, dld_r};
  assign hrdata_o      = rdata_r;
  assign hreadyout_o   = resetn_r;
  assign hresp_o       = 1'b0 & resetn_r;
  assign lock_pin_o    = lock_pin_r;
  assign status_pin_o  = status_r;
  assign reference_monitor_pin_pin_o  = reference_monitor_pin_r;
  assign cp_hiz_o      = hiz_r;
  assign b_cnt_reset_o = brst_r;

  // assertions
  dld_rise_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(dld_r) |-> $past(in_lock) && ($past(lkc_r) + 8'h01 >= $past(need)))
    else $error("lock indicated without enough in-window cycles");
  dld_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(dld_r) |-> $past(out_lock) || $past(ld_dis))
    else $error("lock dropped without an out-of-window cycle");
  need_five_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r18_r[6:5] == 2'b00) |-> (need == 8'h05))
    else $error("counter field 00 does not need five cycles");
  dld_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ld_dis |=> !dld_r && (lkc_r == 8'h00))
    else $error("lock indicator active while disabled");
  qual_reset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (csrc && !dld_r) |=> (qc_r == 8'h00) && !cmp)
    else $error("qualification not restarted on false indicator");
  ho_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !ho_en |=> !cp_hiz_o)
    else $error("holdover active while disabled");
  manual_entry_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ho_en && ho_ext && st_r == HO_IDLE && sync_fall) |=> cp_hiz_o)
    else $error("manual holdover not entered on sync fall");
  release_brst_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($fell(cp_hiz_o) && $past(ho_en)) |-> b_cnt_reset_o && $past(ref_rise))
    else $error("release without reference edge and B reset");
  auto_entry_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ho_en && !ho_ext && st_r == HO_IDLE && !ld_sense) |=> cp_hiz_o)
    else $error("automatic holdover not entered on lock loss");
  no_reentry_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_r == HO_RELCK && !(dld_r && ld_sense)) |=> !cp_hiz_o)
    else $error("holdover re-entered before relock");
  lock_pin_src_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    csrc |=> (lock_pin_o == dld_r))
    else $error("lock pin does not follow the indicator in current-source mode");
  status_pol_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r17_r[7:2] == `MSEL_CMP_HI) |=> (status_pin_o == $past(cmp)))
    else $error("status pin does not show the comparator");
  reference_monitor_pin_pol_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ({1'b0, r1b_r[4:0]} == `MSEL_CMP_LO) |=> (reference_monitor_pin_pin_o == !$past(cmp)))
    else $error("monitor pin does not show the inverted comparator");
  auto_no_sync_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ho_en && !ho_ext && st_r == HO_IDLE && ld_sense) |=> !cp_hiz_o)
    else $error("automatic holdover entered while lock is sensed");
  hiz_until_ref_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cp_hiz_o && ho_en && !ref_rise) |=> cp_hiz_o)
    else $error("charge pump released without a reference edge");
  sync_low_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cp_hiz_o && ho_en && ho_ext && !sync_high) |=> cp_hiz_o)
    else $error("manual holdover released while sync pin low");
  brst_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    b_cnt_reset_o |=> !b_cnt_reset_o)
    else $error("B counter reset longer than one cycle");
endmodule // pll_lock_detect_holdover
`default_nettype wire

// File: testbench/pll_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pll_far_side (
  input  wire logic clk_i,
  output logic      ref_o,
  output logic      fb_o,
  output logic      syncn_o
);
  initial begin
    ref_o   = 1'b0;
    fb_o    = 1'b0;
    syncn_o = 1'b1;
  end
  // n ten-clock detector periods, fb lags ref by off clocks (off <= 7)
  task automatic cycles(input int n, input int off);
    repeat (n) begin
      for (int t = 0; t < 10; t++) begin
        @(posedge clk_i);
        ref_o <= (t < 2);
        fb_o  <= (t >= off) && (t < off + 2);
      end
    end
  endtask
  // low-going sync pin pulse held for len clocks
  task automatic sync_pulse(input int len);
    @(posedge clk_i);
    syncn_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    syncn_o <= 1'b1;
  endtask
endmodule // pll_far_side
`default_nettype wire

// File: testbench/pll_lock_detect_holdover_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module pll_lock_detect_holdover_tb;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ref_pfd;
  logic        fb_pfd;
  logic        syncn;
  logic        lock_pin;
  logic        status_pin;
  logic        reference_monitor_pin_pin;
  logic        cp_hiz;
  logic        b_cnt_reset;
  logic        prev_hiz = 1'b0;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_hiz = 0;
  int          n_brst = 0;

  always #50 clk_i = ~clk_i;

  pll_lock_detect_holdover uut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .ref_pfd_i(ref_pfd), .fb_pfd_i(fb_pfd), .syncn_i(syncn),
    .lock_pin_o(lock_pin), .status_pin_o(status_pin), .reference_monitor_pin_pin_o(reference_monitor_pin_pin),
    .cp_hiz_o(cp_hiz), .b_cnt_reset_o(b_cnt_reset));
  pll_far_side far (.clk_i(clk_i), .ref_o(ref_pfd), .fb_o(fb_pfd), .syncn_o(syncn));

  always @(posedge clk_i) begin
    if (prev_hiz === 1'b1 && cp_hiz === 1'b0) `CHK("b_cnt_reset_o", 1'b1, b_cnt_reset)
    if (b_cnt_reset === 1'b1) n_brst++;
    if (prev_hiz === 1'b0 && cp_hiz === 1'b1) n_hiz++;
    prev_hiz <= cp_hiz;
  end

  task automatic wait_ready();
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] ex);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    `CHK("hrdata_o", ex, r)
  endtask
  task automatic run(input int n, input int off);
    far.cycles(n, off);
    repeat (5) @(posedge clk_i);
  endtask

  task automatic t_regs();
    for (int i = 8'h17; i <= 8'h1d; i++) rdchk(i[7:0], 32'h0);
    wr(8'h18, 32'hffff_ff74);
    rdchk(8'h18, 32'h74);
    wr(8'h30, 32'h5a);
    rdchk(8'h30, 32'h0);
    `CHK("hresp_o", 1'b0, hresp)
    wr(8'h18, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_lock();
    int   cfg[6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h20};
    int   ab[6]  = '{0, 0, 1, 0, 0, 0};
    int   off[6] = '{0, 3, 3, 2, 0, 0};
    int   n[6]   = '{5, 5, 5, 5, 5, 16};
    logic ex[6]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      wr(8'h18, 32'h8);
      wr(8'h17, ab[i]);
      wr(8'h1a, 32'h1);
      wr(8'h18, cfg[i]);
      run(n[i] - 1, off[i]);
      `CHK("lock_pin_o early", 1'b0, lock_pin)
      run(1, off[i]);
      `CHK("lock_pin_o", ex[i], lock_pin)
    end
    $display("test lock done");
  endtask
  task automatic t_hyst();
    wr(8'h18, 32'h0);
    run(5, 0);
    run(3, 5);
    `CHK("lock_pin_o held", 1'b1, lock_pin)
    run(1, 7);
    `CHK("lock_pin_o lost", 1'b0, lock_pin)
    wr(8'h18, 32'h8);
    run(6, 0);
    `CHK("lock_pin_o disabled", 1'b0, lock_pin)
    wr(8'h18, 32'h0);
    $display("test hysteresis done");
  endtask
  task automatic t_csrc();
    wr(8'h18, 32'h8);
    wr(8'h18, 32'h0);
    wr(8'h1a, 32'h4);
    wr(8'h17, 32'h8);
    wr(8'h1b, 32'h3);
    run(5, 0);
    `CHK("lock_pin_o", 1'b1, lock_pin)
    `CHK("status_pin_o", 1'b0, status_pin)
    run(65, 0);
    `CHK("status_pin_o", 1'b1, status_pin)
    `CHK("reference_monitor_pin_pin_o", 1'b0, reference_monitor_pin_pin)
    run(1, 7);
    `CHK("lock_pin_o", 1'b0, lock_pin)
    `CHK("status_pin_o", 1'b0, status_pin)
    run(5, 0);
    `CHK("lock_pin_o", 1'b1, lock_pin)
    `CHK("status_pin_o", 1'b0, status_pin)
    wr(8'h1a, 32'h1);
    wr(8'h17, 32'h0);
    wr(8'h1b, 32'h0);
    $display("test current source done");
  endtask
  task automatic t_manual();
    int b0;
    int dis[3] = '{32'h3, 32'h6, 32'h5};
    // dividers outside this block are assumed to ignore the sync pin
    wr(8'h1d, 32'h7);
    far.sync_pulse(6);
    `CHK("cp_hiz_o", 1'b1, cp_hiz)
    repeat (30) @(posedge clk_i);
    `CHK("cp_hiz_o no ref", 1'b1, cp_hiz)
    b0 = n_brst;
    run(1, 0);
    `CHK("cp_hiz_o", 1'b0, cp_hiz)
    `CHK("b_cnt_reset pulses", b0 + 1, n_brst)
    for (int i = 0; i < 3; i++) begin
      wr(8'h1d, dis[i]);
      far.sync_pulse(6);
      repeat (5) @(posedge clk_i);
      `CHK("cp_hiz_o off", 1'b0, cp_hiz)
    end
    $display("test manual holdover done");
  endtask
  task automatic t_auto();
    int h0;
    wr(8'h1d, 32'hd);
    run(5, 0);
    h0 = n_hiz;
    run(1, 7);
    `CHK("cp_hiz_o", 1'b1, cp_hiz)
    rdchk(8'h20, 32'h12);
    run(1, 7);
    `CHK("cp_hiz_o", 1'b0, cp_hiz)
    `CHK("holdover entries", h0 + 1, n_hiz)
    run(5, 0);
    run(1, 7);
    `CHK("holdover entries", h0 + 2, n_hiz)
    run(1, 0);
    wr(8'h1d, 32'h5);
    run(5, 0);
    run(1, 7);
    `CHK("cp_hiz_o no cmp", 1'b0, cp_hiz)
    // holdover left off so a later calibration is not disturbed
    wr(8'h1d, 32'h0);
    $display("test auto holdover done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_regs();
    t_lock();
    t_hyst();
    t_csrc();
    t_manual();
    t_auto();
    wrap_up();
  end
  initial begin
    #2_000_000;
    n_fail++;
    $display("unexpected watchdog expired");
    wrap_up();
  end
endmodule // pll_lock_detect_holdover_tb
`default_nettype wire
